// *** include/smwt_clk_if.sv ***
// Carrier between the sequencer and its sync flash clock divider.
// Assumes both ends sit on ref_clk.
`timescale 1ns/100ps
interface smwt_clk_if;
  logic div2;
  logic div4;
  logic sync_clk;
  modport ctrl (output div2, output div4, input sync_clk);
  modport div  (input div2, input div4, output sync_clk);
endinterface

// *** include/smwt_pkg.sv ***
// Shared constants for the static memory write sequencer.
// Assumes every count is in memory-clock (ref_clk) cycles.
package smwt_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 26;
  localparam int DATA_W  = 32;
  localparam int MASK_W  = 4;
  localparam int DLY_W   = 5;
  localparam int RECOV_W = 3;
  localparam int LAT_W   = 4;

  // ---------------------------------------------------------------
  // Phase lengths in cycles and the frequency code offset
  // ---------------------------------------------------------------
  localparam logic [DLY_W-1:0] ADDR_SETUP_CYC = 5'h01;  // Address before chip select.
  localparam logic [DLY_W-1:0] CS_SETUP_CYC   = 5'h02;  // Chip select before strobe.
  localparam logic [DLY_W-1:0] STROBE_HOLD_CYC = 5'h01; // Select, address, data after strobe.
  localparam logic [LAT_W-1:0] FREQ_CODE_OFFSET = 4'h1; // Latency code minus this is the frequency code.

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CSSET = 3'b010,
    ST_WSTB  = 3'b011,
    ST_HOLD  = 3'b100,
    ST_NADDR = 3'b101,
    ST_RSTB  = 3'b110,
    ST_RECOV = 3'b111
  } smwt_state_t;

endpackage

// *** src/smwt_clkdiv.sv ***
// Sync flash clock divider: ref_clk divided by 1, 2 or 4.
// Assumes divider selects are quasi-static while flash is idle.
`timescale 1ns/100ps
module smwt_clkdiv (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Divider carrier
  smwt_clk_if.div   cif
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // ---------------------------------------------------------------
  // Free-running divide counter
  // ---------------------------------------------------------------
  // Count advances only while the clock enable is high.
  always_comb
  begin
    cnt_next = ce ? cnt_reg + 2'h1 : cnt_reg;
  end

  // Register the counter.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_next;
  end

  // Divide by 4 wins over divide by 2; neither set passes the clock straight through. [RQ16]
  assign cif.sync_clk = cif.div4 ? cnt_reg[1] : (cif.div2 ? cnt_reg[0] : ref_clk);

endmodule // smwt_clkdiv

// *** src/smwt_ctrl.sv ***
// Static memory write/read sequencer for asynchronous flash and SRAM.
// Assumes request fields are on ref_clk; memory_data_bus_in comes from a pin.
// Operation
// RQ1: Frequency config code counts sync clocks from READ command to first data.
// RQ2: Latency code 0b0100 maps to frequency config code 3.
// RQ3: Address leads strobe by 3 cycles on first beat, 1 on later beats.
// RQ4: Address is valid exactly 1 cycle before chip select asserts.
// RQ5: Chip select asserts exactly 2 cycles before write strobe.
// RQ6: Chip select stays asserted exactly 1 cycle after strobe release.
// RQ7: Address holds exactly 1 cycle after strobe release.
// RQ8: Strobe low delay+1 cycles; data and masks lead release by delay+2.
// RQ9: Data and masks stay driven exactly 1 cycle after strobe release.
// RQ10: Chip select stays high at least twice recovery plus one cycles.
// RQ11: Flash write data valid at least 1.5 cycles before address change.
// RQ12: Flash write data may change when the address changes.
// RQ13: Data pins are driven throughout a write, whatever the masks.
// RQ14: SRAM byte masks act as byte enables; memory stores enabled bytes.
// RQ15: SRAM reads use the plain non-burst ROM read sequence.
// RQ16: Sync flash clock is memory clock divided by 1, 2 or 4.
// RQ17: A state machine with loaded cycle counters sequences every phase.
`timescale 1ns/100ps
module smwt_ctrl (
  // Clock, reset, enable
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // Timing configuration
  input  wire logic [smwt_pkg::DLY_W-1:0]  first_access_delay,
  input  wire logic [smwt_pkg::DLY_W-1:0]  next_access_delay,
  input  wire logic [smwt_pkg::RECOV_W-1:0] chip_select_recovery,
  input  wire logic [smwt_pkg::LAT_W-1:0]  first_access_latency_code,
  input  wire logic                        sync_clock_div2,
  input  wire logic                        sync_clock_div4,
  // Request port
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic                        req_flash,
  input  wire logic                        req_last,
  input  wire logic [smwt_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [smwt_pkg::DATA_W-1:0] req_data,
  input  wire logic [smwt_pkg::MASK_W-1:0] req_mask,
  // Status
  output logic                             busy,
  output logic                             rd_valid,
  output logic [smwt_pkg::DATA_W-1:0]      rd_data,
  output logic [smwt_pkg::LAT_W-1:0]       frequency_config_code,
  // Memory pins
  output logic [smwt_pkg::ADDR_W-1:0]      mem_addr,
  output logic                             static_chip_select_n,
  output logic                             write_strobe_n,
  output logic                             read_strobe_n,
  output logic [smwt_pkg::MASK_W-1:0]      byte_mask_n,
  output logic [smwt_pkg::DATA_W-1:0]      memory_data_bus_out,
  output logic                             memory_data_bus_oe,
  input  wire logic [smwt_pkg::DATA_W-1:0] memory_data_bus_in,
  output logic                             sync_flash_clock
);

  smwt_pkg::smwt_state_t           st_reg, st_next;
  logic [smwt_pkg::DLY_W-1:0]      cnt_reg, cnt_next;
  logic                            flash_reg, flash_next;
  logic                            write_reg, write_next;
  logic [3:0]                      cs_gap_reg, cs_gap_next, rec_min_reg, rec_min_next;
  logic                            last_reg, last_next;
  logic [smwt_pkg::ADDR_W-1:0]     addr_reg, addr_next;
  logic [smwt_pkg::DATA_W-1:0]     wdat_reg, wdat_next;
  logic [smwt_pkg::MASK_W-1:0]     mask_reg, mask_next;
  logic                            oe_reg, oe_next;
  logic                            rdv_reg, rdv_next;
  logic [smwt_pkg::DATA_W-1:0]     rdat_reg, rdat_next;
  logic [smwt_pkg::LAT_W-1:0]      freq_code_reg, freq_code_next;
  logic [smwt_pkg::DATA_W-1:0]     din_s1_reg, din_s2_reg;
  logic [smwt_pkg::DLY_W-1:0]      dly;
  logic                            take;

  // ---------------------------------------------------------------
  // Sync flash clock divider
  // ---------------------------------------------------------------
  smwt_clk_if cif ();
  assign cif.div2 = sync_clock_div2;
  assign cif.div4 = sync_clock_div4;
  smwt_clkdiv u_clkdiv (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cif     (cif)
  );
  assign sync_flash_clock = cif.sync_clk; // [RQ16]

  // ---------------------------------------------------------------
  // Read data pin synchroniser
  // ---------------------------------------------------------------
  // Two stages before any logic looks at the bus.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end
    else if (ce)
    begin
      din_s1_reg <= memory_data_bus_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Flash strobe width comes from the first-access field, SRAM from the next-access field.
  assign dly       = flash_reg ? first_access_delay : next_access_delay; // [RQ8]
  assign req_ready = ce && (st_reg == smwt_pkg::ST_IDLE || (st_reg == smwt_pkg::ST_HOLD && !last_reg));
  assign take      = req_ready && req_valid;

  // Next state, counters and pin values; phase lengths are loaded counters except the one-cycle ST_HOLD and ST_NADDR. [RQ17]
  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    flash_next = flash_reg;
    write_next = write_reg;
    // Count high select cycles, saturating, and keep the gap owed by the last access. [RQ10]
    cs_gap_next  = static_chip_select_n ? ((cs_gap_reg == 4'hf) ? cs_gap_reg : cs_gap_reg + 4'h1) : 4'h0;
    rec_min_next = static_chip_select_n ? rec_min_reg : {chip_select_recovery, 1'b0} + 4'h1;
    last_next  = last_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    mask_next  = mask_reg;
    oe_next    = 1'b0;
    rdv_next   = 1'b0;
    rdat_next  = rdat_reg;
    // Latency code less one: code 0b0100 gives frequency code 3. [RQ1] [RQ2]
    freq_code_next = first_access_latency_code - smwt_pkg::FREQ_CODE_OFFSET;
    unique case (st_reg)
      smwt_pkg::ST_IDLE:
      begin
        if (take)
        begin
          st_next    = smwt_pkg::ST_ADDR;
          cnt_next   = smwt_pkg::ADDR_SETUP_CYC - 5'h01;
          flash_next = req_flash;
          write_next = req_write;
          last_next  = req_last || !req_write;
          addr_next  = req_addr;
          wdat_next  = req_data;
          mask_next  = req_mask;
        end
      end
      smwt_pkg::ST_ADDR:
      begin
        // Address alone for one cycle, then select. [RQ4]
        if (cnt_reg == 5'h00)
        begin
          st_next  = write_reg ? smwt_pkg::ST_CSSET : smwt_pkg::ST_RSTB;
          cnt_next = write_reg ? smwt_pkg::CS_SETUP_CYC - 5'h01 : dly;
        end
        else
          cnt_next = cnt_reg - 5'h01;
      end
      smwt_pkg::ST_CSSET:
      begin
        // Select leads strobe by two cycles; data goes out in the second. [RQ5] [RQ8]
        oe_next = (cnt_reg == 5'h01);
        if (cnt_reg == 5'h00)
        begin
          st_next  = smwt_pkg::ST_WSTB;
          cnt_next = dly;
          oe_next  = 1'b1;
        end
        else
          cnt_next = cnt_reg - 5'h01;
      end
      smwt_pkg::ST_WSTB:
      begin
        // Strobe low for delay plus one cycles, bus driven whatever the masks. [RQ8] [RQ13]
        oe_next = 1'b1;
        if (cnt_reg == 5'h00)
          st_next = smwt_pkg::ST_HOLD;
        else
          cnt_next = cnt_reg - 5'h01;
      end
      smwt_pkg::ST_HOLD:
      begin
        // One cycle of select, address, data and mask hold after release. [RQ6] [RQ7] [RQ9]
        if (take)
        begin
          // Next burst beat: address and data change together. [RQ3] [RQ12]
          st_next   = smwt_pkg::ST_NADDR;
          last_next = req_last;
          addr_next = req_addr;
          wdat_next = req_data;
          mask_next = req_mask;
          oe_next   = 1'b1;
        end
        else
        begin
          st_next  = smwt_pkg::ST_RECOV;
          cnt_next = {1'b0, chip_select_recovery, 1'b0}; // [RQ10]
        end
      end
      smwt_pkg::ST_NADDR:
      begin
        // Later beats set up the address one cycle before the strobe. [RQ3]
        st_next  = smwt_pkg::ST_WSTB;
        cnt_next = dly;
        oe_next  = 1'b1;
      end
      smwt_pkg::ST_RSTB:
      begin
        // Plain ROM-style read: select and read strobe for delay plus one cycles. [RQ15]
        if (cnt_reg == 5'h00)
        begin
          st_next   = smwt_pkg::ST_RECOV;
          cnt_next  = {1'b0, chip_select_recovery, 1'b0};
          rdv_next  = 1'b1;
          rdat_next = din_s2_reg;
        end
        else
          cnt_next = cnt_reg - 5'h01;
      end
      smwt_pkg::ST_RECOV:
      begin
        // Select stays high twice recovery plus one cycles before any new access. [RQ10]
        if (cnt_reg == 5'h00)
          st_next = smwt_pkg::ST_IDLE;
        else
          cnt_next = cnt_reg - 5'h01;
      end
    endcase
  end

  // Register the sequencer; the clock enable freezes everything.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg    <= smwt_pkg::ST_IDLE;
      cnt_reg   <= '0;
      flash_reg <= 1'b0;
      last_reg  <= 1'b1;
      write_reg <= 1'b0;
      cs_gap_reg  <= 4'hf;
      rec_min_reg <= 4'h1;
      addr_reg  <= '0;
      wdat_reg  <= '0;
      mask_reg  <= '0;
      oe_reg    <= 1'b0;
      rdv_reg   <= 1'b0;
      rdat_reg  <= '0;
      freq_code_reg <= '0;
    end
    else if (ce)
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      flash_reg <= flash_next;
      last_reg  <= last_next;
      write_reg <= write_next;
      cs_gap_reg  <= cs_gap_next;
      rec_min_reg <= rec_min_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      mask_reg  <= mask_next;
      oe_reg    <= oe_next;
      rdv_reg   <= rdv_next;
      rdat_reg  <= rdat_next;
      freq_code_reg <= freq_code_next;
    end
  end

  // ---------------------------------------------------------------
  // Pin decode from registered state
  // ---------------------------------------------------------------
  // Masks low enable a byte lane; the memory keeps only enabled bytes. [RQ14]
  assign static_chip_select_n  = (st_reg == smwt_pkg::ST_IDLE || st_reg == smwt_pkg::ST_ADDR ||
                                  st_reg == smwt_pkg::ST_RECOV);
  assign write_strobe_n        = (st_reg != smwt_pkg::ST_WSTB);
  assign read_strobe_n         = (st_reg != smwt_pkg::ST_RSTB);
  assign mem_addr              = addr_reg;
  assign byte_mask_n           = ~mask_reg;
  assign memory_data_bus_out   = wdat_reg;
  assign memory_data_bus_oe    = oe_reg;
  assign busy                  = (st_reg != smwt_pkg::ST_IDLE);
  assign rd_valid              = rdv_reg;
  assign rd_data               = rdat_reg;
  assign frequency_config_code = freq_code_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_ADDR_BEFORE_CS: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
    ce && $fell(static_chip_select_n) |-> $past(st_reg) == smwt_pkg::ST_ADDR)
    else $error("Chip select asserted without one address cycle.");
  AST_CS_TO_WE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
    ce && $fell(static_chip_select_n) && write_reg |-> ##1 ce [*1] ##0 !static_chip_select_n ##1 !write_strobe_n)
    else $error("Write strobe not two cycles after chip select.");
  AST_CS_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ6]
    ce && $rose(write_strobe_n) |-> !static_chip_select_n)
    else $error("Chip select released with strobe.");
  AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
    ce && $rose(write_strobe_n) |-> mem_addr == $past(mem_addr))
    else $error("Address changed at strobe release.");
  AST_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ9]
    ce && $rose(write_strobe_n) |-> memory_data_bus_oe && memory_data_bus_out == $past(memory_data_bus_out))
    else $error("Write data not held after strobe release.");
  AST_DRIVE_DURING_WE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ13]
    !write_strobe_n |-> memory_data_bus_oe)
    else $error("Data bus not driven while strobe low.");
  AST_RECOVERY: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
    ce && $fell(static_chip_select_n) |-> cs_gap_reg >= rec_min_reg)
    else $error("Chip select recovery too short.");
  AST_FREQ_CODE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ2]
    ce && first_access_latency_code == 4'h4 ##1 ce |-> frequency_config_code == 4'h3)
    else $error("Latency code 4 did not give frequency code 3.");
  AST_STROBE_WIDTH: assert property (@(posedge ref_clk) disable iff (rst) // [RQ8]
    ce && $fell(write_strobe_n) && dly == 5'h00 |-> ##1 write_strobe_n)
    else $error("Strobe width wrong for zero delay.");

endmodule // smwt_ctrl

// *** verification/smwt_mem_model.sv ***
// Behavioural flash/SRAM device on the far side of the static memory pins.
// Assumes the bench resolves the shared data bus and feeds it back here.
`timescale 1ns/100ps
module smwt_mem_model (
  // Control pins from the sequencer
  input  logic [smwt_pkg::ADDR_W-1:0] mem_addr,
  input  logic                        static_chip_select_n,
  input  logic                        write_strobe_n,
  input  logic                        read_strobe_n,
  input  logic [smwt_pkg::MASK_W-1:0] byte_mask_n,
  // Data bus as seen on the board
  input  logic [smwt_pkg::DATA_W-1:0] memory_data_bus,
  output logic [smwt_pkg::DATA_W-1:0] drv_data,
  output logic                        drv_oe
);
  logic [31:0] store [0:15];
  logic [31:0] last_drv;

  // Sixteen words, cleared at start.
  initial
  begin
    for (int i = 0; i < 16; i++)
      store[i] = 32'h0;
    last_drv = 32'h0;
  end

  // Commit only the enabled byte lanes when the strobe is released.
  always @(posedge write_strobe_n)
  begin
    if (static_chip_select_n == 1'b0)
    begin
      for (int b = 0; b < 4; b++)
        if (byte_mask_n[b] == 1'b0)
          store[mem_addr[3:0]][8*b +: 8] = memory_data_bus[8*b +: 8];
    end
  end

  // Drive read data while selected with the read strobe low; a released bus shows the inverse of the last word.
  assign drv_oe = !static_chip_select_n && !read_strobe_n;
  always @*
  begin
    if (drv_oe)
      last_drv = store[mem_addr[3:0]];
  end
  assign drv_data = drv_oe ? store[mem_addr[3:0]] : ~last_drv;
endmodule // smwt_mem_model

// *** verification/tb.sv ***
// Self-checking bench for the static memory write/read sequencer.
// Assumes the sequencer top is smwt_ctrl and a behavioural memory sits on its pins.
`timescale 1ns/100ps
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                        ref_clk, rst, ce, sync_clock_div2, sync_clock_div4;
  logic [smwt_pkg::DLY_W-1:0]  first_access_delay, next_access_delay;
  logic [smwt_pkg::RECOV_W-1:0] chip_select_recovery;
  logic [smwt_pkg::LAT_W-1:0]  first_access_latency_code, frequency_config_code;
  logic                        req_valid, req_ready, req_write, req_flash, req_last;
  logic [smwt_pkg::ADDR_W-1:0] req_addr, mem_addr;
  logic [smwt_pkg::DATA_W-1:0] req_data, rd_data, memory_data_bus_out, bus_wire, mdl_data;
  logic [smwt_pkg::MASK_W-1:0] req_mask, byte_mask_n;
  logic                        busy, rd_valid, static_chip_select_n, write_strobe_n, read_strobe_n;
  logic                        memory_data_bus_oe, sync_flash_clock, mdl_oe;
  int                          failures, n_tests, cycles;

  // The board bus: the sequencer wins while it drives, else the memory.
  assign bus_wire = memory_data_bus_oe ? memory_data_bus_out : mdl_data;

  smwt_ctrl i_smwt_ctrl (.ref_clk(ref_clk), .rst(rst), .ce(ce), .first_access_delay(first_access_delay),
    .next_access_delay(next_access_delay), .chip_select_recovery(chip_select_recovery),
    .first_access_latency_code(first_access_latency_code), .sync_clock_div2(sync_clock_div2),
    .sync_clock_div4(sync_clock_div4), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_flash(req_flash), .req_last(req_last), .req_addr(req_addr), .req_data(req_data), .req_mask(req_mask),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .frequency_config_code(frequency_config_code),
    .mem_addr(mem_addr), .static_chip_select_n(static_chip_select_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .byte_mask_n(byte_mask_n), .memory_data_bus_out(memory_data_bus_out),
    .memory_data_bus_oe(memory_data_bus_oe), .memory_data_bus_in(bus_wire), .sync_flash_clock(sync_flash_clock));

  smwt_mem_model i_smwt_mem_model (.mem_addr(mem_addr), .static_chip_select_n(static_chip_select_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .byte_mask_n(byte_mask_n),
    .memory_data_bus(bus_wire), .drv_data(mdl_data), .drv_oe(mdl_oe));

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------
  // A 50 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Cut a hung run short; the tests need well under 2000 cycles.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      $display("mismatch at %0t: run timed out", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Counts one comparison and reports a miss at once.
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Raises a request and returns just after the edge that takes it.
  task automatic issue(input logic wr, fl, lst, input logic [25:0] a, input logic [31:0] dat,
                       input logic [3:0] m);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_flash <= fl;
    req_last  <= lst;
    req_addr  <= a;
    req_data  <= dat;
    req_mask  <= m;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(req_ready === 1'b1, "request not accepted");
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(busy === 1'b0, "sequencer stays busy");
  endtask

  // Walks one write beat cycle by cycle; a last beat also walks the recovery gap.
  task automatic beat(input logic first, last, input int d, r, input logic [25:0] a,
                      input logic [31:0] dat, input logic [3:0] m);
    int s, cs0, kend;
    s = first ? 4 : 2;
    cs0 = first ? 2 : 1;
    kend = last ? s + d + 2 + 2 * r : s + d;
    for (int k = 1; k <= kend; k++)
    begin
      @(negedge ref_clk);
      if (k <= s + d + 1)
        chk(mem_addr === a, "address not held");
      chk(static_chip_select_n === !(k >= cs0 && k <= s + d + 1), "chip select timing");
      chk(write_strobe_n === !(k >= s && k <= s + d), "write strobe timing");
      chk(memory_data_bus_oe === (k >= s - 1 && k <= s + d + 1), "data drive window");
      if (k >= s - 1 && k <= s + d + 1)
        chk(memory_data_bus_out === dat && byte_mask_n === ~m, "data or mask");
    end
  endtask

  // Counts sync clock rises over 16 memory clocks.
  task automatic div_chk(input logic d2, d4, input int exp);
    int cnt;
    logic prev;
    @(posedge ref_clk);
    sync_clock_div2 <= d2;
    sync_clock_div4 <= d4;
    repeat (4) @(negedge ref_clk);
    prev = sync_flash_clock;
    cnt = 0;
    repeat (16)
    begin
      @(negedge ref_clk);
      if (prev === 1'b0 && sync_flash_clock === 1'b1)
        cnt++;
      prev = sync_flash_clock;
    end
    chk(cnt == exp, "sync clock rate");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_fcc();
    logic [3:0] codes [3] = '{4'h2, 4'h4, 4'h8};
    foreach (codes[i])
    begin
      @(posedge ref_clk);
      first_access_latency_code <= codes[i];
      repeat (3) @(negedge ref_clk);
      chk(frequency_config_code === codes[i] - 4'h1, "frequency code");
    end
    $display("test fcc done");
  endtask

  task automatic t_div();
    div_chk(1'b1, 1'b0, 8);
    div_chk(1'b1, 1'b1, 4);
    div_chk(1'b0, 1'b0, 0);
    #1;
    chk(sync_flash_clock === 1'b0, "undivided sync clock");
    @(posedge ref_clk);
    #1;
    chk(sync_flash_clock === 1'b1, "undivided sync clock high");
    $display("test div done");
  endtask

  // Single flash writes at a short delay and at delay 30 with the longest recovery.
  task automatic t_flash();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      first_access_delay   <= (i == 0) ? 5'h02 : 5'h1e;
      next_access_delay    <= 5'h05;
      chip_select_recovery <= (i == 0) ? 3'h1 : 3'h7;
      issue(1'b1, 1'b1, 1'b1, 26'h0000008, 32'h5a5a0f0f, 4'h0);
      beat(1'b1, 1'b1, (i == 0) ? 2 : 30, (i == 0) ? 1 : 7, 26'h0000008, 32'h5a5a0f0f, 4'h0);
      wait_idle();
    end
    $display("test flash done");
  endtask

  // Two-beat SRAM burst with a one-cycle strobe, then a partial-mask read back.
  task automatic t_sram();
    @(posedge ref_clk);
    first_access_delay   <= 5'h09;
    next_access_delay    <= 5'h00;
    chip_select_recovery <= 3'h0;
    issue(1'b1, 1'b0, 1'b0, 26'h0000001, 32'haabbccdd, 4'hf);
    beat(1'b1, 1'b0, 0, 0, 26'h0000001, 32'haabbccdd, 4'hf);
    issue(1'b1, 1'b0, 1'b1, 26'h0000001, 32'h11223344, 4'h5);
    beat(1'b0, 1'b1, 0, 0, 26'h0000001, 32'h11223344, 4'h5);
    wait_idle();
    @(posedge ref_clk);
    first_access_delay <= 5'h03;
    next_access_delay  <= 5'h03;
    issue(1'b0, 1'b0, 1'b1, 26'h0000001, 32'h0, 4'h0);
    for (int k = 1; k <= 6; k++)
    begin
      @(negedge ref_clk);
      chk(static_chip_select_n === !(k >= 2 && k <= 5) && read_strobe_n === !(k >= 2 && k <= 5), "read");
      chk(rd_valid === (k == 6), "read valid timing");
      chk(memory_data_bus_oe === 1'b0 && mdl_oe === (k >= 2 && k <= 5), "read bus drive");
      if (k == 6)
        chk(rd_data === 32'haa22cc44, "read data");
    end
    wait_idle();
    $display("test sram done");
  endtask

  // A low clock enable freezes a flash write in mid-strobe.
  task automatic t_freeze();
    @(posedge ref_clk);
    first_access_delay   <= 5'h02;
    chip_select_recovery <= 3'h0;
    issue(1'b1, 1'b1, 1'b1, 26'h0000004, 32'h0f0f5a5a, 4'hf);
    repeat (4) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (5)
    begin
      @(negedge ref_clk);
      chk(write_strobe_n === 1'b0 && static_chip_select_n === 1'b0 && memory_data_bus_oe === 1'b1, "frozen");
    end
    @(posedge ref_clk);
    ce <= 1'b1;
    wait_idle();
    $display("test freeze done");
  endtask

  // Main sequence: every input set at time zero, reset for 16 clocks.
  initial
  begin
    failures = 0;
    n_tests = 0;
    cycles = 0;
    rst = 1'b1;
    ce = 1'b1;
    sync_clock_div2 = 1'b0;
    sync_clock_div4 = 1'b0;
    first_access_delay = 5'h00;
    next_access_delay = 5'h00;
    chip_select_recovery = 3'h0;
    first_access_latency_code = 4'h1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_flash = 1'b0;
    req_last = 1'b1;
    req_addr = 26'h0;
    req_data = 32'h0;
    req_mask = 4'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_fcc();
    t_div();
    t_flash();
    t_sram();
    t_freeze();
    stop_test();
  end
endmodule // tb
